/* File: compare_if.sv */
`timescale 1ns/10ps
`default_nettype none

// Links the channel control to its compare engine.
interface compare_if;
   logic timebase_select;
   logic run;
   logic [15:0] compare_value;
   logic [15:0] secondary_value;
   logic primary_event;
   logic secondary_event;
   logic rollover;

   modport ctrl (
      output timebase_select, run, compare_value, secondary_value,
      input primary_event, secondary_event, rollover
   );
   modport unit (
      input timebase_select, run, compare_value, secondary_value,
      output primary_event, secondary_event, rollover
   );
endinterface

`default_nettype wire

/* File: compare_unit.sv */
`timescale 1ns/10ps
`default_nettype none

module compare_unit (
   input wire logic core_clk_in,           // Clock.
   input wire logic rst_in,                // Asynchronous reset, high.
   input wire logic ce_in,                 // Clock enable.
   input wire logic [15:0] timer_b_count_in, // Timer b count.
   input wire logic [15:0] timer_c_count_in, // Timer c count.
   input wire logic timer_b_rollover_in,   // Timer b period pulse.
   input wire logic timer_c_rollover_in,   // Timer c period pulse.
   compare_if.unit cmp                     // Link to control.
);

   logic [15:0] count;
   logic match;
   logic match2;
   logic match_q;
   logic match2_q;

   // Pick the timebase; a one selects timer c.
   assign count = cmp.timebase_select ? timer_c_count_in : timer_b_count_in;
   assign cmp.rollover = cmp.timebase_select ? timer_c_rollover_in : timer_b_rollover_in;

   // Equality with the programmed values.
   assign match = (count == cmp.compare_value);
   assign match2 = (count == cmp.secondary_value);

   // A prescaled timer may hold one count for many cycles, so only the
   // first cycle of a match is an event.
   assign cmp.primary_event = match && !match_q;
   assign cmp.secondary_event = match2 && !match2_q;

   // Match history, frozen while the channel is halted.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         match_q <= 1'b0;
         match2_q <= 1'b0;
      end else if (ce_in && cmp.run) begin
         match_q <= match;
         match2_q <= match2;
      end
   end

endmodule

`default_nettype wire

/* File: oc_pkg.sv */
`default_nettype none

package oc_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   localparam int IRQ_W = 3;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] CMP_OFS = 4'h1;
   localparam logic [3:0] CMP2_OFS = 4'h2;
   localparam logic [3:0] IRQ_STAT_OFS = 4'h3;
   localparam logic [3:0] IRQ_EN_OFS = 4'h4;
   localparam logic [3:0] IRQ_CLR_OFS = 4'h5;

   // ****************************************
   // Control field positions
   // ****************************************
   localparam int IDLE_HALT_BIT = 13;
   localparam int FAULT_BIT = 4;
   localparam int TSEL_BIT = 3;
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 2;

   // ****************************************
   // Interrupt bit positions and reset values
   // ****************************************
   localparam int IRQ_CMP_BIT = 0;
   localparam int IRQ_CMP2_BIT = 1;
   localparam int IRQ_FAULT_BIT = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   // ****************************************
   // Modes and pulse sequencer states
   // ****************************************
   typedef enum logic [2:0] {
      MODE_OFF      = 3'b000,
      MODE_SET_HIGH = 3'b001,
      MODE_SET_LOW  = 3'b010,
      MODE_TOGGLE   = 3'b011,
      MODE_SINGLE   = 3'b100,
      MODE_CONT     = 3'b101,
      MODE_PWM      = 3'b110,
      MODE_PWM_FLT  = 3'b111
   } mode_t;

   typedef enum logic [1:0] {
      PULSE_WAIT = 2'b00,
      PULSE_HIGH = 2'b01,
      PULSE_DONE = 2'b10
   } pulse_state_t;

   // True for both pulse modes.
   function automatic logic is_pulse(input mode_t m);
      return (m == MODE_SINGLE) || (m == MODE_CONT);
   endfunction

endpackage

`default_nettype wire

/* File: oc_props.sv */
`timescale 1ns/10ps
`default_nettype none

// *****
// Port checker
// *****
module oc_props (
   input wire logic core_clk_in, // Clock.
   input wire logic rst_in, // Reset.
   input wire logic ce_in, // Enable.
   input wire logic [3:0] addr_in, // Address.
   input wire logic [15:0] wdata_in, // Write data.
   input wire logic wr_in, // Write.
   input wire logic rd_in, // Read.
   input wire logic [15:0] rdata_out, // Read data.
   input wire logic cpu_idle_in, // Idle.
   input wire logic fault_n_in, // Fault.
   input wire logic [15:0] timer_b_count_in, // Timer b.
   input wire logic [15:0] timer_c_count_in, // Timer c.
   input wire logic compare_output_pin_out // Pin.
);
   logic [2:0] mode;
   logic tsel;
   logic idle;
   logic [15:0] cmp;
   logic match_d;
   logic wc;
   logic run;
   logic evt;

   // Event seen from the ports: the selected count first equals the compare value.
   assign wc = ce_in && wr_in && addr_in == oc_pkg::CTRL_OFS;
   assign run = ce_in && !(idle && cpu_idle_in);
   assign evt = run && !match_d && (tsel ? timer_c_count_in : timer_b_count_in) == cmp;

   // Shadow copies of control and compare, taken from bus writes.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mode <= 3'h0;
         tsel <= 1'b0;
         idle <= 1'b0;
      end else if (wc) begin
         mode <= wdata_in[2:0];
         tsel <= wdata_in[3];
         idle <= wdata_in[13];
      end
   end

   // Compare shadow and match history; the history freezes with the channel.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cmp <= 16'h0000;
         match_d <= 1'b0;
      end else begin
         if (ce_in && wr_in && addr_in == oc_pkg::CMP_OFS) cmp <= wdata_in;
         if (run) match_d <= (tsel ? timer_c_count_in : timer_b_count_in) == cmp;
      end
   end

   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   a_unused_read_zero: assert property (
      $past(ce_in && rd_in && addr_in == oc_pkg::CTRL_OFS) |-> rdata_out[15:14] == 2'h0 && rdata_out[12:5] == 8'h00)
      else $error("unused control bits read nonzero");
   a_fault_flag_quiet: assert property (
      $past(ce_in && rd_in && addr_in == oc_pkg::CTRL_OFS && mode != 3'h7) |-> !rdata_out[4])
      else $error("fault flag set outside fault mode");
   a_off_stays_low: assert property (mode == 3'h0 |-> !compare_output_pin_out)
      else $error("disabled channel drives pin");
   a_write_inits_pin: assert property (
      $past(wc) |-> compare_output_pin_out == ($past(wdata_in[2:0]) == 3'h2))
      else $error("wrong initial pin level");
   a_event_sets_pin: assert property (evt && !wc && mode == 3'h1 |=> compare_output_pin_out)
      else $error("compare did not set pin");
   a_event_clears_pin: assert property (evt && !wc && mode == 3'h2 |=> !compare_output_pin_out)
      else $error("compare did not clear pin");
   a_event_toggles: assert property (
      evt && !wc && mode == 3'h3 |=> compare_output_pin_out != $past(compare_output_pin_out))
      else $error("compare did not toggle pin");
   a_fault_forces_low: assert property (run && !wc && mode == 3'h7 && !fault_n_in |=> !compare_output_pin_out)
      else $error("fault did not force pin low");
   a_halt_holds_pin: assert property (ce_in && idle && cpu_idle_in && !wr_in |=> $stable(compare_output_pin_out))
      else $error("pin moved while halted");
endmodule

bind output_compare_channel oc_props oc_props_inst (.core_clk_in, .rst_in, .ce_in, .addr_in, .wdata_in, .wr_in,
   .rd_in, .rdata_out, .cpu_idle_in, .fault_n_in, .timer_b_count_in, .timer_c_count_in, .compare_output_pin_out);

`default_nettype wire

/* File: output_compare_channel.sv */
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Idle-halt bit set stops channel in CPU idle.
// - Hardware sets fault flag; software cannot write it.
// - Fault flag stays zero outside mode 111.
// - Timebase select one picks timer c, else b.
// - Mode 111 is PWM with fault input.
// - Mode 110 is PWM ignoring fault input.
// - Mode 101 starts low, continuous compare pulses.
// - Mode 100 starts low, exactly one pulse.
// - Mode 011 toggles output on each compare.
// - Mode 010 starts high, compare drives low.
// - Mode 001 starts low, compare drives high.
// - Mode 000 disables channel, no compare activity.
// - Unused control bits ignore writes, read zero.

module output_compare_channel (
   input wire logic core_clk_in,            // Clock, 100 MHz.
   input wire logic rst_in,                 // Asynchronous reset, high.
   input wire logic ce_in,                  // Clock enable; low freezes all.
   input wire logic [3:0] addr_in,          // Register address.
   input wire logic [15:0] wdata_in,        // Write data.
   input wire logic wr_in,                  // Write strobe.
   input wire logic rd_in,                  // Read strobe.
   output logic [15:0] rdata_out,           // Read data, one cycle later.
   input wire logic cpu_idle_in,            // CPU is in idle mode.
   input wire logic fault_n_in,             // PWM fault input, low active.
   input wire logic [15:0] timer_b_count_in, // Timer b count.
   input wire logic [15:0] timer_c_count_in, // Timer c count.
   input wire logic timer_b_rollover_in,    // Timer b period pulse.
   input wire logic timer_c_rollover_in,    // Timer c period pulse.
   output logic compare_output_pin_out,     // Channel output pin.
   output logic irq_out                     // Level interrupt.
);

   // ****************************************
   // Declarations
   // ****************************************
   compare_if cmp ();

   logic idle_halt;
   logic timebase_select;
   oc_pkg::mode_t compare_mode_field;
   oc_pkg::mode_t next_mode;
   logic pwm_fault_flag;
   logic [15:0] compare_value;
   logic [15:0] secondary_value;
   logic [2:0] irq_status;
   logic [2:0] irq_enable;
   logic [2:0] irq_set;
   logic [2:0] irq_clear;
   oc_pkg::pulse_state_t pulse_state;
   logic run;
   logic ctrl_write;
   logic fault_active;
   logic fault_rise;
   logic pulse_end;

   // True when a write strobe addresses the given register.
   function automatic logic wr_hit(input logic wr, input logic [3:0] a,
                                   input logic [3:0] ofs);
      return wr && (a == ofs);
   endfunction

   // ****************************************
   // Run gating
   // ****************************************

   // The channel halts in idle only when asked to; the register port
   // stays live so software can reprogram a halted channel.
   assign run = ce_in && !(idle_halt && cpu_idle_in);

   assign ctrl_write = ce_in && wr_hit(wr_in, addr_in, oc_pkg::CTRL_OFS);

   // The mode that holds after this cycle, used to judge the fault flag.
   assign next_mode = ctrl_write ?
      oc_pkg::mode_t'(wdata_in[oc_pkg::MODE_MSB:oc_pkg::MODE_LSB]) :
      compare_mode_field;

   // Only the fault-enabled mode looks at the fault input at all.
   assign fault_active = (compare_mode_field == oc_pkg::MODE_PWM_FLT) &&
                         !fault_n_in;

   // ****************************************
   // Compare engine link
   // ****************************************
   assign cmp.timebase_select = timebase_select;
   assign cmp.run = run;
   assign cmp.compare_value = compare_value;
   assign cmp.secondary_value = secondary_value;

   compare_unit u_compare (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .timer_b_count_in(timer_b_count_in),
      .timer_c_count_in(timer_c_count_in),
      .timer_b_rollover_in(timer_b_rollover_in),
      .timer_c_rollover_in(timer_c_rollover_in),
      .cmp(cmp)
   );

   // ****************************************
   // Control register
   // ****************************************

   // Only bits 13, 3 and 2..0 are stored; every other bit is dropped.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         idle_halt <= 1'b0;
         timebase_select <= 1'b0;
         compare_mode_field <= oc_pkg::MODE_OFF;
      end else if (ctrl_write) begin
         idle_halt <= wdata_in[oc_pkg::IDLE_HALT_BIT];
         timebase_select <= wdata_in[oc_pkg::TSEL_BIT];
         compare_mode_field <= next_mode;
      end
   end

   // ****************************************
   // Compare values
   // ****************************************

   // Primary value drives every mode but 000; the secondary ends a pulse.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         compare_value <= oc_pkg::WORD_RESET;
         secondary_value <= oc_pkg::WORD_RESET;
      end else if (ce_in) begin
         if (wr_hit(wr_in, addr_in, oc_pkg::CMP_OFS)) begin
            compare_value <= wdata_in;
         end
         if (wr_hit(wr_in, addr_in, oc_pkg::CMP2_OFS)) begin
            secondary_value <= wdata_in;
         end
      end
   end

   // ****************************************
   // Fault flag
   // ****************************************

   // A fault arriving in the cycle of a mode rewrite still sets the flag,
   // provided the new mode keeps the fault input enabled.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pwm_fault_flag <= 1'b0;
      end else if (ce_in) begin
         if (next_mode != oc_pkg::MODE_PWM_FLT) begin
            pwm_fault_flag <= 1'b0;
         end else if (run && fault_active) begin
            pwm_fault_flag <= 1'b1;
         end else if (ctrl_write) begin
            pwm_fault_flag <= 1'b0;
         end
      end
   end

   assign fault_rise = run && fault_active && !pwm_fault_flag &&
                       (next_mode == oc_pkg::MODE_PWM_FLT);

   // ****************************************
   // Output pin and pulse sequencer
   // ****************************************

   // A control write re-initialises the pin for the new mode and wins over
   // any compare event of the same cycle.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         compare_output_pin_out <= 1'b0;
         pulse_state <= oc_pkg::PULSE_WAIT;
      end else if (ctrl_write) begin
         compare_output_pin_out <= (next_mode == oc_pkg::MODE_SET_LOW);
         pulse_state <= oc_pkg::PULSE_WAIT;
      end else if (run) begin
         case (compare_mode_field)
            oc_pkg::MODE_OFF: begin
               compare_output_pin_out <= 1'b0;
            end
            oc_pkg::MODE_SET_HIGH: begin
               if (cmp.primary_event) begin
                  compare_output_pin_out <= 1'b1;
               end
            end
            oc_pkg::MODE_SET_LOW: begin
               if (cmp.primary_event) begin
                  compare_output_pin_out <= 1'b0;
               end
            end
            oc_pkg::MODE_TOGGLE: begin
               if (cmp.primary_event) begin
                  compare_output_pin_out <= !compare_output_pin_out;
               end
            end
            oc_pkg::MODE_SINGLE, oc_pkg::MODE_CONT: begin
               case (pulse_state)
                  oc_pkg::PULSE_WAIT: begin
                     if (cmp.primary_event) begin
                        compare_output_pin_out <= 1'b1;
                        pulse_state <= oc_pkg::PULSE_HIGH;
                     end
                  end
                  oc_pkg::PULSE_HIGH: begin
                     if (cmp.secondary_event) begin
                        compare_output_pin_out <= 1'b0;
                        // Continuous mode re-arms; single mode stops until the next control write.
                        pulse_state <= (compare_mode_field == oc_pkg::MODE_CONT) ?
                                       oc_pkg::PULSE_WAIT : oc_pkg::PULSE_DONE;
                     end
                  end
                  oc_pkg::PULSE_DONE: begin
                     compare_output_pin_out <= 1'b0;
                  end
                  default: begin
                     pulse_state <= oc_pkg::PULSE_WAIT;
                  end
               endcase
            end
            oc_pkg::MODE_PWM, oc_pkg::MODE_PWM_FLT: begin
               // The pin stays low until the flag is cleared by a rewrite.
               if (fault_active || pwm_fault_flag) begin
                  compare_output_pin_out <= 1'b0;
               end else if (cmp.primary_event) begin
                  compare_output_pin_out <= 1'b0;
               end else if (cmp.rollover) begin
                  compare_output_pin_out <= 1'b1;
               end
            end
            default: begin
               compare_output_pin_out <= 1'b0;
            end
         endcase
      end
   end

   // End of a pulse, seen by the interrupt logic.
   assign pulse_end = run && !ctrl_write &&
                      oc_pkg::is_pulse(compare_mode_field) &&
                      (pulse_state == oc_pkg::PULSE_HIGH) &&
                      cmp.secondary_event;

   // ****************************************
   // Interrupts
   // ****************************************

   assign irq_set[oc_pkg::IRQ_CMP_BIT] = run && cmp.primary_event &&
                                         (compare_mode_field != oc_pkg::MODE_OFF);
   assign irq_set[oc_pkg::IRQ_CMP2_BIT] = pulse_end;
   assign irq_set[oc_pkg::IRQ_FAULT_BIT] = fault_rise;

   assign irq_clear = wr_hit(wr_in, addr_in, oc_pkg::IRQ_CLR_OFS) ?
                      wdata_in[2:0] : oc_pkg::IRQ_RESET;

   // Set wins over clear so an event in the clearing cycle survives.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_status <= oc_pkg::IRQ_RESET;
      end else if (ce_in) begin
         irq_status <= (irq_status & ~irq_clear) | irq_set;
      end
   end

   // Enable mask, same layout as the status.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_enable <= oc_pkg::IRQ_RESET;
      end else if (ce_in && wr_hit(wr_in, addr_in, oc_pkg::IRQ_EN_OFS)) begin
         irq_enable <= wdata_in[2:0];
      end
   end

   assign irq_out = |(irq_status & irq_enable);

   // ****************************************
   // Read port
   // ****************************************

   // Data stand only in the cycle after the strobe; unmapped reads and
   // the write-only clear register return zero.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_out <= oc_pkg::WORD_RESET;
      end else if (ce_in) begin
         rdata_out <= oc_pkg::WORD_RESET;
         if (rd_in) begin
            case (addr_in)
               oc_pkg::CTRL_OFS: begin
                  rdata_out[oc_pkg::IDLE_HALT_BIT] <= idle_halt;
                  rdata_out[oc_pkg::FAULT_BIT] <= pwm_fault_flag;
                  rdata_out[oc_pkg::TSEL_BIT] <= timebase_select;
                  rdata_out[oc_pkg::MODE_MSB:oc_pkg::MODE_LSB] <= compare_mode_field;
               end
               oc_pkg::CMP_OFS: begin
                  rdata_out <= compare_value;
               end
               oc_pkg::CMP2_OFS: begin
                  rdata_out <= secondary_value;
               end
               oc_pkg::IRQ_STAT_OFS: begin
                  rdata_out[2:0] <= irq_status;
               end
               oc_pkg::IRQ_EN_OFS: begin
                  rdata_out[2:0] <= irq_enable;
               end
               default: begin
                  rdata_out <= oc_pkg::WORD_RESET;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

/* File: output_compare_channel_tb.sv */
`timescale 1ns/10ps
`default_nettype none

// *****
// Channel testbench; map 0 ctrl, 1 cmp, 2 pulse end, 3 status, 4 enable, 5 clear
// *****
module output_compare_channel_tb;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic ce_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [15:0] wdata_in = 16'h0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic cpu_idle_in = 1'b0;
   logic fault_n_in = 1'b1;
   logic [15:0] rdata_out;
   logic [15:0] timer_b_count_in;
   logic [15:0] timer_c_count_in;
   logic timer_b_rollover_in;
   logic timer_c_rollover_in;
   logic compare_output_pin_out;
   logic irq_out;
   int errors = 0;
   int checked = 0;
   int cycles = 0;

   // Clock at 100 MHz.
   always #5 core_clk_in = ~core_clk_in;

   timebase_model timebase_model_inst (.core_clk_in, .rst_in, .b_count_out(timer_b_count_in),
      .c_count_out(timer_c_count_in), .b_roll_out(timer_b_rollover_in), .c_roll_out(timer_c_rollover_in));

   output_compare_channel output_compare_channel_inst (.core_clk_in, .rst_in, .ce_in, .addr_in, .wdata_in,
      .wr_in, .rd_in, .rdata_out, .cpu_idle_in, .fault_n_in, .timer_b_count_in, .timer_c_count_in,
      .timer_b_rollover_in, .timer_c_rollover_in, .compare_output_pin_out, .irq_out);

   task automatic give_verdict();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // A hang is cut short well after the tests should have ended.
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         give_verdict();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Bus cycles; each returns just after the edge that took it, so effects have landed.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge core_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1;
      chk(rdata_out, exp);
   endtask

   task automatic wait_pin(input logic lvl, input int n);
      for (int i = 0; i < n && compare_output_pin_out !== lvl; i++) begin
         @(posedge core_clk_in);
         #1;
      end
      chk({15'h0000, compare_output_pin_out}, {15'h0000, lvl});
   endtask

   task automatic hold_pin(input logic lvl, input int n);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(posedge core_clk_in);
         #1;
         if (compare_output_pin_out !== lvl) ok = 1'b0;
      end
      chk({15'h0000, ok}, 16'h0001);
   endtask

   task automatic t_regs();
      rd(4'h0, 16'h0000);
      wr(4'h0, 16'hffff);
      rd(4'h0, 16'h200f);
      rd(4'hf, 16'h0000);
      wr(4'h0, 16'h0000);
      $display("registers done");
   endtask

   task automatic t_edges();
      logic [2:0] m;
      for (int i = 1; i <= 3; i++) begin
         m = 3'(i);
         wr(4'h1, 16'h0005);
         wr(4'h0, {13'h0000, m});
         chk({15'h0000, compare_output_pin_out}, {15'h0000, m == 3'h2});
         wait_pin(m != 3'h2, 20);
      end
      wait_pin(1'b0, 20);
      $display("edge modes done");
   endtask

   task automatic t_tsel();
      wr(4'h1, 16'h0014);
      wr(4'h0, 16'h0009);
      wait_pin(1'b1, 40);
      wr(4'h0, 16'h0001);
      hold_pin(1'b0, 40);
      $display("timebase done");
   endtask

   task automatic t_pulse();
      wr(4'h1, 16'h0004);
      wr(4'h2, 16'h0009);
      wr(4'h0, 16'h0004);
      wait_pin(1'b1, 20);
      wait_pin(1'b0, 10);
      hold_pin(1'b0, 40);
      wr(4'h0, 16'h0005);
      wait_pin(1'b1, 20);
      wait_pin(1'b0, 10);
      wait_pin(1'b1, 20);
      $display("pulses done");
   endtask

   // The fault stays asserted through the 110 and 111 writes and is released before the rewrite that clears the flag.
   task automatic t_pwm();
      @(posedge core_clk_in);
      fault_n_in <= 1'b0;
      wr(4'h1, 16'h0008);
      wr(4'h0, 16'h0016);
      wait_pin(1'b1, 20);
      wait_pin(1'b0, 20);
      rd(4'h0, 16'h0006);
      wr(4'h0, 16'h0007);
      hold_pin(1'b0, 40);
      rd(4'h0, 16'h0017);
      @(posedge core_clk_in);
      fault_n_in <= 1'b1;
      wr(4'h0, 16'h0007);
      rd(4'h0, 16'h0007);
      wait_pin(1'b1, 20);
      $display("pwm done");
   endtask

   task automatic t_idle();
      wr(4'h1, 16'h0003);
      @(posedge core_clk_in);
      cpu_idle_in <= 1'b1;
      wr(4'h0, 16'h2003);
      hold_pin(1'b0, 40);
      @(posedge core_clk_in);
      cpu_idle_in <= 1'b0;
      wait_pin(1'b1, 20);
      @(posedge core_clk_in);
      cpu_idle_in <= 1'b1;
      wr(4'h0, 16'h0003);
      wait_pin(1'b1, 20);
      @(posedge core_clk_in);
      cpu_idle_in <= 1'b0;
      $display("idle done");
   endtask

   task automatic t_irq();
      wr(4'h0, 16'h0000);
      wr(4'h5, 16'h0007);
      rd(4'h3, 16'h0000);
      wr(4'h4, 16'h0001);
      chk({15'h0000, irq_out}, 16'h0000);
      wr(4'h1, 16'h0002);
      wr(4'h0, 16'h0003);
      wait_pin(1'b1, 20);
      chk({15'h0000, irq_out}, 16'h0001);
      rd(4'h3, 16'h0001);
      wr(4'h4, 16'h0000);
      chk({15'h0000, irq_out}, 16'h0000);
      wr(4'h4, 16'h0001);
      chk({15'h0000, irq_out}, 16'h0001);
      wr(4'h5, 16'h0001);
      chk({15'h0000, irq_out}, 16'h0000);
      rd(4'h5, 16'h0000);
      rd(4'h4, 16'h0001);
      // Pulse end and fault raise their own status bits.
      wr(4'h0, 16'h0000);
      wr(4'h5, 16'h0007);
      wr(4'h2, 16'h0006);
      rd(4'h2, 16'h0006);
      wr(4'h0, 16'h0004);
      wait_pin(1'b1, 20);
      wait_pin(1'b0, 10);
      rd(4'h3, 16'h0003);
      // A compare value the timer never reaches keeps bit 0 quiet below.
      wr(4'h1, 16'h00ff);
      rd(4'h1, 16'h00ff);
      wr(4'h5, 16'h0007);
      @(posedge core_clk_in);
      fault_n_in <= 1'b0;
      wr(4'h0, 16'h0007);
      rd(4'h3, 16'h0004);
      rd(4'h0, 16'h0017);
      $display("interrupt done");
   endtask

   // With the enable low every strobe is lost, so the fault flag must survive.
   task automatic t_freeze();
      @(posedge core_clk_in);
      ce_in <= 1'b0;
      fault_n_in <= 1'b1;
      wr(4'h0, 16'h0000);
      wr(4'h1, 16'h0000);
      @(posedge core_clk_in);
      ce_in <= 1'b1;
      rd(4'h0, 16'h0017);
      rd(4'h1, 16'h00ff);
      hold_pin(1'b0, 20);
      $display("freeze done");
   endtask

   // Reset for two cycles, then each scenario in turn.
   initial begin
      repeat (2) @(posedge core_clk_in);
      rst_in <= 1'b0;
      t_regs();
      t_edges();
      t_tsel();
      t_pulse();
      t_pwm();
      t_idle();
      t_irq();
      t_freeze();
      give_verdict();
   end
endmodule

`default_nettype wire

/* File: timebase_model.sv */
`timescale 1ns/10ps
`default_nettype none

// *****
// Timer pair seen by the channel
// *****
module timebase_model #(
   parameter int PER_B = 16, // Timer b period.
   parameter int PER_C = 32 // Timer c period.
) (
   input wire logic core_clk_in, // Clock.
   input wire logic rst_in, // Reset.
   output logic [15:0] b_count_out, // Timer b count.
   output logic [15:0] c_count_out, // Timer c count.
   output logic b_roll_out, // Timer b period pulse.
   output logic c_roll_out // Timer c period pulse.
);
   // Periods differ, so a wrong timebase choice moves the compare time.
   assign b_roll_out = b_count_out == 16'(PER_B - 1);
   assign c_roll_out = c_count_out == 16'(PER_C - 1);

   // Both timers count up and wrap after their last count.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         b_count_out <= 16'h0000;
         c_count_out <= 16'h0000;
      end else begin
         b_count_out <= b_roll_out ? 16'h0000 : b_count_out + 16'h0001;
         c_count_out <= c_roll_out ? 16'h0000 : c_count_out + 16'h0001;
      end
   end
endmodule

`default_nettype wire
